// file: inc/wk_pkg.sv
// Constants and types shared by the wake detection block
// Overview of operation
// - Pin 7 wakes on PHY link-up in modes zero and three.
// - Pins 0-7 internal PHY only; 8-10 in either PHY mode.
// - Five LAN enables form composite LAN wake.
// - LAN or energy-detect enable raises wake interrupt.
// - Two status bits: LAN wake, energy detect.
// - Separate received flags for four LAN event types, none for global unicast.
// - LAN wake remote wake only in mode zero.
// - Energy detect remote wake only in mode one.
// - Wake interrupt drives remote wake output.
// - All LAN enables clear: good frame wakes.
// - Good frame sets the LAN status bit.
// - Good frame remote wake only in mode three.
// - Enabled pins wake in every suspend mode; link-up on pin 7 only in zero and three.
// - Pins 0-7 need generation-disable bit cleared.
// - Pins 8-10 wake only as plain inputs.
// - Per-pin enable and polarity gate each pin.
// - Link-up enable: pin 7 ignores pad level.
// - Pin wake resumes, sets per-pin status.
// - LAN status refuses clear while event asserted.
// - Energy status refuses clear while PHY interrupt.
// - Four suspend modes, mode two default.
package wk_pkg;
  localparam int NPINS = 11;
  localparam int NLOW  = 8;

  // Register byte offsets
  localparam logic [7:0] OFS_PMC     = 8'h00;
  localparam logic [7:0] OFS_LANCS   = 8'h04;
  localparam logic [7:0] OFS_PINWAKE = 8'h08;
  localparam logic [7:0] OFS_PINCFG  = 8'h0C;
  localparam logic [7:0] OFS_PINHI   = 8'h10;
  localparam logic [7:0] OFS_INTSTS  = 8'h14;
  localparam logic [7:0] OFS_HWCFG   = 8'h18;

  // Field positions
  localparam int PMC_MODE_LSB = 0;
  localparam int PMC_LANEN    = 2;
  localparam int PMC_EDEN     = 3;
  localparam int PMC_WAKEUP_STATUS_BITS_LSB = 4;
  localparam int PMC_SUSP     = 8;
  localparam int PMC_WINT     = 9;
  localparam int LCS_EN_LSB   = 0;
  localparam int LCS_RX_LSB   = 5;
  localparam int PW_EN_LSB    = 0;
  localparam int PW_POL_LSB   = 16;
  localparam int PW_LINK      = 31;
  localparam int HI_FSEL_LSB  = 0;
  localparam int HI_DIR_LSB   = 8;
  localparam int HW_EXTPHY    = 0;

  // Values after reset, and the plain-input function code
  localparam logic [7:0] GEN_DIS_RST = 8'hFF;
  localparam logic [5:0] FSEL_RST    = 6'h00;
  localparam logic [1:0] FSEL_GPIN   = 2'h0;

  // Suspend modes in field order 00b..11b
  typedef enum logic [1:0] {
    WK_SUSP0,
    WK_SUSP1,
    WK_SUSP2,
    WK_SUSP3
  } wk_susp_t;

  localparam wk_susp_t MODE_RST = WK_SUSP2;

  // Sticky flag update: a set in the clear cycle wins
  function automatic logic [10:0] wk_sticky(
    input logic [10:0] cur,
    input logic [10:0] set,
    input logic [10:0] clr
  );
    return (cur & ~clr) | set;
  endfunction
endpackage

// file: design/wk_sync2.sv
// Two-stage synchroniser bank for pad inputs
`timescale 1ns/10ps
`default_nettype none
module wk_sync2 #(
  parameter int W = 11
) (
  input  wire logic         clk,
  input  wire logic         srst,
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } wk_sync_t;

  wk_sync_t s_r;
  wk_sync_t s_nxt;

  // First stage feeds only the second stage
  always_comb begin
    s_nxt    = s_r;
    s_nxt.s1 = d;
    s_nxt.s2 = s_r.s1;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign q = s_r.s2;
endmodule // wk_sync2
`default_nettype wire

// file: design/wk_pin_qual.sv
// Per-pin wake qualification for the eleven general purpose pins
`timescale 1ns/10ps
`default_nettype none
module wk_pin_qual
  import wk_pkg::*;
(
  input  wire logic [10:0] pin_sync,
  input  wire logic [10:0] pin_wake_enable,
  input  wire logic [10:0] pin_wake_polarity,
  input  wire logic [7:0]  pin_wake_gen_enable,
  input  wire logic [5:0]  pin_function_select,
  input  wire logic [2:0]  pin_direction,
  input  wire logic        link_up_wake_enable,
  input  wire logic        phy_link_up,
  input  wire logic        ext_phy_mode,
  input  wire wk_susp_t    susp_mode,
  output var  logic [10:0] pin_ev
);
  logic [10:0] gen_ok;
  logic [10:0] lvl_ok;

  // Enable and level test for each pin
  always_comb begin
    gen_ok = '0;
    lvl_ok = '0;
    pin_ev = '0;
    for (int i = 0; i < NLOW; i++) begin
      gen_ok[i] = ~pin_wake_gen_enable[i] & ~ext_phy_mode;
    end
    for (int k = 0; k < NPINS - NLOW; k++) begin
      gen_ok[NLOW+k] = (pin_function_select[2*k +: 2] == FSEL_GPIN) &
                       ~pin_direction[k];
    end
    for (int i = 0; i < NPINS; i++) begin
      lvl_ok[i] = (pin_sync[i] == pin_wake_polarity[i]);
      pin_ev[i] = pin_wake_enable[i] & gen_ok[i] & lvl_ok[i];
    end
    // Link-up replaces the pad on pin 7, modes zero and three only
    if (link_up_wake_enable) begin
      pin_ev[7] = pin_wake_enable[7] & gen_ok[7] & phy_link_up &
                  ((susp_mode == WK_SUSP0) | (susp_mode == WK_SUSP3));
    end
  end
endmodule // wk_pin_qual
`default_nettype wire

// file: design/wk_wake_detect.sv
// Wake event detection and remote wake generation with APB registers
//
// Design decisions made here: the address map and the APB slave port.
`timescale 1ns/10ps
`default_nettype none
module wk_wake_detect
  import wk_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  input  wire logic        ev_global_unicast,
  input  wire logic        ev_magic_pkt,
  input  wire logic        ev_wake_frame,
  input  wire logic        ev_perfect_dest,
  input  wire logic        ev_broadcast,
  input  wire logic        ev_good_frame,
  input  wire logic        phy_int,
  input  wire logic        phy_link_up,
  input  wire logic        suspend_req,
  input  wire logic        resume_req,
  input  wire logic [10:0] gpio_in,
  output var  logic        remote_wake,
  output var  logic        wake_int,
  output var  logic        suspended
);
  // Whole block state
  typedef struct packed {
    wk_susp_t    susp_mode;
    logic        lan_wake_enable;
    logic        energy_detect_enable;
    logic [1:0]  wakeup_status_bits;
    logic [4:0]  lan_ens;
    logic [3:0]  lan_rx;
    logic [10:0] pin_wake_enable;
    logic [10:0] pin_wake_polarity;
    logic        link_up_wake_enable;
    logic [7:0]  pin_wake_gen_enable;
    logic [5:0]  pin_function_select;
    logic [2:0]  pin_direction;
    logic [10:0] pin_interrupt_status;
    logic        ext_phy_mode;
    logic        in_susp;
    logic        remote_wake;
    logic        wake_int;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } wk_state_t;

  wk_state_t st_r;
  wk_state_t st_nxt;

  logic [10:0] pin_sync;
  logic [10:0] pin_ev;
  logic [4:0]  lan_evs;
  logic [4:0]  lan_hit;
  logic [3:0]  rx_set;
  logic        all_off;
  logic        mac_lan;
  logic        good_ev;
  logic        mac_wake_ev;
  logic        lan_irq;
  logic        ed_irq;
  logic        pin_irq;
  logic        lan_rw;
  logic        ed_rw;
  logic        wake_now;
  logic        setup_ph;
  logic        wr_go;
  logic        mapped;
  logic [31:0] rd_word;
  logic [1:0]  wakeup_status_bits_clr;
  logic [3:0]  rx_clr;
  logic [10:0] pin_clr;

  // Pads are asynchronous to clk
  wk_sync2 #(
    .W (NPINS)
  ) u_sync (
    .clk  (clk),
    .srst (srst),
    .d    (gpio_in),
    .q    (pin_sync)
  );

  // Pin enables, polarity and link-up override
  wk_pin_qual u_pins (
    .pin_sync            (pin_sync),
    .pin_wake_enable     (st_r.pin_wake_enable),
    .pin_wake_polarity   (st_r.pin_wake_polarity),
    .pin_wake_gen_enable (st_r.pin_wake_gen_enable),
    .pin_function_select (st_r.pin_function_select),
    .pin_direction       (st_r.pin_direction),
    .link_up_wake_enable (st_r.link_up_wake_enable),
    .phy_link_up         (phy_link_up),
    .ext_phy_mode        (st_r.ext_phy_mode),
    .susp_mode           (st_r.susp_mode),
    .pin_ev              (pin_ev)
  );

  // Composite LAN wake from the five enables
  assign lan_evs = {ev_broadcast, ev_perfect_dest, ev_wake_frame,
                    ev_magic_pkt, ev_global_unicast};
  assign lan_hit = st_r.lan_ens & lan_evs;
  assign mac_lan = |lan_hit;
  assign all_off = ~|st_r.lan_ens;
  // Good frame counts only with every LAN enable clear
  assign good_ev = all_off & ev_good_frame;
  assign mac_wake_ev = mac_lan | good_ev;

  // Received flags: wake frame, magic, perfect, broadcast
  assign rx_set = {lan_hit[4], lan_hit[3], lan_hit[1], lan_hit[2]};

  // Wake interrupt sources; status bits keep them alive
  assign lan_irq = st_r.wakeup_status_bits[1] &
                   (st_r.lan_wake_enable | all_off);
  assign ed_irq  = st_r.wakeup_status_bits[0] &
                   st_r.energy_detect_enable;
  assign pin_irq = |st_r.pin_interrupt_status;

  // Suspend-mode gating of each source
  assign lan_rw = lan_irq &
                  ((~all_off & (st_r.susp_mode == WK_SUSP0)) |
                   (all_off & (st_r.susp_mode == WK_SUSP3)));
  assign ed_rw = ed_irq & (st_r.susp_mode == WK_SUSP1);
  // Pins wake from any suspend mode
  assign wake_now = st_r.in_susp & (lan_rw | ed_rw | pin_irq);

  // Bus phases
  assign setup_ph = psel & ~penable;
  assign wr_go    = psel & penable & st_r.pready & pwrite;

  // Address decode and read data
  always_comb begin
    mapped  = 1'b1;
    rd_word = 32'h0000_0000;
    case (paddr)
      OFS_PMC: begin
        rd_word[PMC_MODE_LSB +: 2] = st_r.susp_mode;
        rd_word[PMC_LANEN]         = st_r.lan_wake_enable;
        rd_word[PMC_EDEN]          = st_r.energy_detect_enable;
        rd_word[PMC_WAKEUP_STATUS_BITS_LSB +: 2] = st_r.wakeup_status_bits;
        rd_word[PMC_SUSP]          = st_r.in_susp;
        rd_word[PMC_WINT]          = st_r.wake_int;
      end
      OFS_LANCS: begin
        rd_word[LCS_EN_LSB +: 5] = st_r.lan_ens;
        rd_word[LCS_RX_LSB +: 4] = st_r.lan_rx;
      end
      OFS_PINWAKE: begin
        rd_word[PW_EN_LSB +: 11]  = st_r.pin_wake_enable;
        rd_word[PW_POL_LSB +: 11] = st_r.pin_wake_polarity;
        rd_word[PW_LINK]          = st_r.link_up_wake_enable;
      end
      OFS_PINCFG: begin
        rd_word[7:0] = st_r.pin_wake_gen_enable;
      end
      OFS_PINHI: begin
        rd_word[HI_FSEL_LSB +: 6] = st_r.pin_function_select;
        rd_word[HI_DIR_LSB +: 3]  = st_r.pin_direction;
      end
      OFS_INTSTS: begin
        rd_word[10:0] = st_r.pin_interrupt_status;
      end
      OFS_HWCFG: begin
        rd_word[HW_EXTPHY] = st_r.ext_phy_mode;
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
  end

  // Write-one-to-clear masks
  always_comb begin
    wakeup_status_bits_clr = 2'h0;
    rx_clr   = 4'h0;
    pin_clr  = 11'h000;
    if (wr_go && paddr == OFS_PMC) begin
      wakeup_status_bits_clr = pwdata[PMC_WAKEUP_STATUS_BITS_LSB +: 2];
    end
    if (wr_go && paddr == OFS_LANCS) begin
      rx_clr = pwdata[LCS_RX_LSB +: 4];
    end
    if (wr_go && paddr == OFS_INTSTS) begin
      pin_clr = pwdata[10:0];
    end
    // Clear refused while the source is still asserted
    wakeup_status_bits_clr[1] = wakeup_status_bits_clr[1] & ~mac_wake_ev;
    wakeup_status_bits_clr[0] = wakeup_status_bits_clr[0] & ~phy_int;
  end

  // Next-state logic
  always_comb begin
    st_nxt = st_r;

    // No wait state: pready registered from the setup phase, a flop output
    st_nxt.pready  = setup_ph;
    st_nxt.pslverr = setup_ph & ~mapped;
    st_nxt.prdata  = (setup_ph & ~pwrite) ? rd_word : 32'h0000_0000;

    // Control writes
    if (wr_go) begin
      case (paddr)
        OFS_PMC: begin
          st_nxt.susp_mode = wk_susp_t'(pwdata[PMC_MODE_LSB +: 2]);
          st_nxt.lan_wake_enable      = pwdata[PMC_LANEN];
          st_nxt.energy_detect_enable = pwdata[PMC_EDEN];
        end
        OFS_LANCS: begin
          st_nxt.lan_ens = pwdata[LCS_EN_LSB +: 5];
        end
        OFS_PINWAKE: begin
          st_nxt.pin_wake_enable     = pwdata[PW_EN_LSB +: 11];
          st_nxt.pin_wake_polarity   = pwdata[PW_POL_LSB +: 11];
          st_nxt.link_up_wake_enable = pwdata[PW_LINK];
        end
        OFS_PINCFG: begin
          st_nxt.pin_wake_gen_enable = pwdata[7:0];
        end
        OFS_PINHI: begin
          st_nxt.pin_function_select = pwdata[HI_FSEL_LSB +: 6];
          st_nxt.pin_direction       = pwdata[HI_DIR_LSB +: 3];
        end
        OFS_HWCFG: begin
          st_nxt.ext_phy_mode = pwdata[HW_EXTPHY];
        end
        default: begin
          st_nxt.ext_phy_mode = st_r.ext_phy_mode;
        end
      endcase
    end

    // Sticky status; an event in the clear cycle survives
    st_nxt.wakeup_status_bits = 2'(wk_sticky(
      11'(st_r.wakeup_status_bits),
      11'({mac_wake_ev, phy_int}),
      11'(wakeup_status_bits_clr)));
    st_nxt.lan_rx = 4'(wk_sticky(11'(st_r.lan_rx), 11'(rx_set),
                                 11'(rx_clr)));
    st_nxt.pin_interrupt_status = wk_sticky(st_r.pin_interrupt_status,
                                            pin_ev, pin_clr);

    // Internal wake interrupt level
    st_nxt.wake_int = lan_irq | ed_irq | pin_irq;

    // Suspend tracking; a wake returns to normal
    st_nxt.remote_wake = wake_now;
    if (wake_now || resume_req) begin
      st_nxt.in_susp = 1'b0;
    end else if (suspend_req) begin
      st_nxt.in_susp = 1'b1;
    end
  end

  // State register with reset values
  always_ff @(posedge clk) begin
    if (srst) begin
      st_r                      <= '0;
      st_r.susp_mode            <= MODE_RST;
      st_r.pin_wake_gen_enable  <= GEN_DIS_RST;
      st_r.pin_function_select  <= FSEL_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Every output straight from the state register
  assign prdata      = st_r.prdata;
  assign pready      = st_r.pready;
  assign pslverr     = st_r.pslverr;
  assign remote_wake = st_r.remote_wake;
  assign wake_int    = st_r.wake_int;
  assign suspended   = st_r.in_susp;
endmodule // wk_wake_detect
`default_nettype wire

// file: tb/wk_wake_detect_assertions.sv
// Port-level checks for the wake detection block
`timescale 1ns/10ps
`default_nettype none
module wk_wake_detect_assertions (
  input wire logic        clk,
  input wire logic        srst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        suspend_req,
  input wire logic        resume_req,
  input wire logic        remote_wake,
  input wire logic        suspended
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // Setup step, then the answered access step
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_done;
    psel && penable && pready;
  endsequence
  AST_APB_ANSWER: assert property (s_setup |=> s_done)
    else $error("access phase not answered at once");
  AST_UNMAPPED: assert property (psel && !penable && paddr > 8'h18 |=> pslverr && prdata == 0)
    else $error("unmapped access not refused");
  AST_ERR_READY: assert property (pslverr |-> pready)
    else $error("error flag without ready");
  AST_PRDATA_IDLE: assert property (!pready |-> prdata == 32'h0000_0000)
    else $error("read data outside access");
  AST_RW_SUSP: assert property (remote_wake |-> $past(suspended) && !suspended)
    else $error("wake pulse without leaving suspend");
  AST_RW_PULSE: assert property (remote_wake |=> !remote_wake)
    else $error("wake pulse longer than one cycle");
  AST_SUSP_ENTER: assert property (suspend_req && !resume_req |=> suspended)
    else $error("suspend request not taken");
  AST_SUSP_HOLD: assert property (suspended && !resume_req |=> suspended || remote_wake)
    else $error("suspend left without cause");
  AST_RESUME: assert property (resume_req |=> !suspended)
    else $error("resume request ignored");
endmodule // wk_wake_detect_assertions
`default_nettype wire

// file: tb/wk_apb_host.sv
// APB master standing in for host software
`timescale 1ns/10ps
`default_nettype none
module wk_apb_host (
  input  wire logic        clk,
  output var  logic        psel,
  output var  logic        penable,
  output var  logic        pwrite,
  output var  logic [7:0]  paddr,
  output var  logic [31:0] pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
  end
  // One transfer, held until pready is sampled; idle edge after it
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e, output logic ok);
    ok = 1'b0;
    q = 32'h0000_0000;
    e = 1'b0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (int n = 0; n < 50 && !ok; n++) begin
      @(posedge clk);
      if (pready) begin
        ok = 1'b1;
        q = prdata;
        e = pslverr;
      end
    end
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~d; // Released data must not look valid
    @(posedge clk);
  endtask
endmodule // wk_apb_host
`default_nettype wire

// file: tb/wk_wake_detect_tb_top.sv
// Self-checking bench for the wake detection block
`timescale 1ns/10ps
`default_nettype none
module wk_wake_detect_tb_top;
  import wk_pkg::*;
  logic        clk;
  logic        srst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [18:0] src;
  logic [10:0] polv;
  logic        suspend_req;
  logic        resume_req;
  logic        remote_wake;
  logic        wake_int;
  logic        suspended;
  wire  [10:0] gpio_in;
  logic [31:0] rnd;
  logic [31:0] q;
  logic        qe;
  int          m;
  int          n_mismatch;
  int          comparisons;
  // Pad sits at the inactive level unless its source bit fires
  assign gpio_in = ~(src[18:8] ^ polv);
  wk_apb_host u_host (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  wk_wake_detect DUT (.clk(clk), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ev_global_unicast(src[0]), .ev_magic_pkt(src[1]),
    .ev_wake_frame(src[2]), .ev_perfect_dest(src[3]), .ev_broadcast(src[4]),
    .ev_good_frame(src[5]), .phy_int(src[6]), .phy_link_up(src[7]),
    .suspend_req(suspend_req), .resume_req(resume_req), .gpio_in(gpio_in),
    .remote_wake(remote_wake), .wake_int(wake_int), .suspended(suspended));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  // Wake expected for source s (8 and up are pins) in mode md
  function automatic logic want(input int s, input int md, input int bad);
    if (s < 5) return md == 0;
    if (s == 5) return md == 3;
    if (s == 6) return md == 1;
    if (s == 7) return md == 0 || md == 3;
    return bad == 0 || (bad == 2 && s >= 16);
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    logic ok;
    u_host.xfer(w, a, d, q, qe, ok);
    if (!ok) begin
      n_mismatch++;
      conclude();
    end
  endtask
  // Clear status, suspend, fire source s, watch a fixed window
  task automatic trial(input int s, input int md, input int bad, input logic [31:0] pmc);
    logic seen;
    logic early;
    seen = 1'b0;
    early = 1'b0;
    acc(1, OFS_INTSTS, 32'h0000_07FF);
    acc(1, OFS_PMC, pmc | 32'h0000_0030 | 32'(md));
    suspend_req <= 1'b1;
    @(posedge clk);
    suspend_req <= 1'b0;
    @(posedge clk);
    src[s] <= 1'b1;
    for (int n = 0; n < 12; n++) begin
      @(posedge clk);
      // A wake this soon predates the source: stale status or bad gating
      if (n < 2) begin
        early = early | remote_wake;
      end
      seen = seen | remote_wake;
      if (n == 5) src[s] <= 1'b0;
    end
    chk("remote_wake", 32'(seen), 32'(want(s, md, bad)));
    chk("early_wake", 32'(early), 32'h0);
    if (!seen) begin
      resume_req <= 1'b1;
      @(posedge clk);
      resume_req <= 1'b0;
    end
    @(posedge clk);
  endtask
  initial begin
    srst = 1'b1;
    suspend_req = 1'b0;
    resume_req = 1'b0;
    src = '0;
    polv = '0;
    rnd = 32'h35e0;
    n_mismatch = 0;
    comparisons = 0;
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    acc(0, OFS_PMC, 32'h0);
    chk("pmc", q, 32'h0000_0002);
    acc(0, OFS_PINCFG, 32'h0);
    chk("pincfg", q, 32'h0000_00FF);
    acc(0, 8'h1C, 32'h0);
    chk("unmapped", {q[30:0], qe}, 32'h1);
    $display("test reset done");
    // Every pin: armed properly, blocked by its config, external PHY mode
    for (int b = 0; b < 3; b++) begin
      for (int i = 0; i < 11; i++) begin
        rnd = xs(rnd);
        polv <= rnd[10:0];
        m = int'(rnd[13:12]);
        acc(1, OFS_HWCFG, 32'(b == 2));
        acc(1, OFS_PINCFG, b == 1 ? 32'h0000_00FF : ~(32'h1 << i) & 32'h0000_00FF);
        acc(1, OFS_PINHI, b == 1 ? (32'h1 << i) & 32'h0000_0700 : 32'h0);
        acc(1, OFS_PINWAKE, (32'h1 << i) | ({21'h0, rnd[10:0]} << 16));
        trial(8 + i, m, b, 32'h0);
        if (want(8 + i, m, b)) begin
          acc(0, OFS_INTSTS, 32'h0);
          chk("intsts", q, 32'h1 << i);
        end
      end
    end
    acc(1, OFS_HWCFG, 32'h0);
    acc(1, OFS_PINWAKE, 32'h0);
    $display("test pins done");
    // Each LAN event alone, in mode zero and in another mode
    for (int k = 0; k < 5; k++) begin
      rnd = xs(rnd);
      acc(1, OFS_LANCS, (32'h1 << k) | 32'h0000_01E0);
      trial(k, 0, 0, 32'h0000_0004);
      chk("wake_int", 32'(wake_int), 32'h1);
      acc(0, OFS_PMC, 32'h0);
      chk("pmc", q & 32'h0000_0023, 32'h0000_0020);
      acc(0, OFS_LANCS, 32'h0);
      chk("rx", (q >> 5) & 32'hF, k == 1 ? 2 : k == 2 ? 1 : k == 0 ? 0 : 1 << (k - 1));
      trial(k, 1 + int'(rnd[1:0]) % 3, 0, 32'h0000_0004);
    end
    $display("test lan done");
    // Clear refused while the event stays high
    acc(1, OFS_LANCS, 32'h0000_0002);
    for (int j = 0; j < 2; j++) begin
      src[j ? 1 : 6] <= 1'b1;
      acc(1, OFS_PMC, 32'h0000_003C);
      acc(0, OFS_PMC, 32'h0);
      chk("held", 32'(q[4 + j]), 32'h1);
      src[j ? 1 : 6] <= 1'b0;
      acc(1, OFS_PMC, 32'h0000_0030);
      acc(0, OFS_PMC, 32'h0);
      chk("cleared", 32'(q[4 + j]), 32'h0);
    end
    $display("test refuse done");
    // Good frame, energy, link-up in all modes; pin 7 pad at wake level
    acc(1, OFS_LANCS, 32'h0000_01E0);
    acc(1, OFS_PINWAKE, 32'h8000_0080);
    acc(1, OFS_PINCFG, 32'h0000_007F);
    polv <= 11'h080;
    for (int s = 5; s < 8; s++) begin
      for (int md = 0; md < 4; md++) begin
        // Good frame runs with the LAN enable clear: it must not matter
        trial(s, md, 0, s == 6 ? 32'h8 : (s == 5 ? 32'h0 : 32'h4));
        if (s == 5 && md == 3) begin
          acc(0, OFS_PMC, 32'h0);
          chk("pmc", q & 32'h0000_0023, 32'h0000_0023);
        end
        if (s == 7 && want(s, md, 0)) begin
          acc(0, OFS_INTSTS, 32'h0);
          chk("intsts", q, 32'h0000_0080);
        end
      end
    end
    $display("test sources done");
    conclude();
  end
endmodule // wk_wake_detect_tb_top
bind wk_wake_detect wk_wake_detect_assertions u_chk (.clk(clk), .srst(srst), .psel(psel),
  .penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .suspend_req(suspend_req), .resume_req(resume_req), .remote_wake(remote_wake),
  .suspended(suspended));
`default_nettype wire
